// ==== logic/upi_desc_if.sv ====
// carrier between the state logic and the descriptor image
// assumes both ends share one clock; the lookup is combinational
`timescale 1ns/100ps
`default_nettype none
interface upi_desc_if;
  logic [upi_pkg::DESC_AW-1:0] addr;
  logic [7:0] data;
  logic [15:0] vid;
  logic [15:0] pid;
  logic [7:0] maxPower;
  modport rom (input addr, input vid, input pid, input maxPower, output data);
  modport user (output addr, output vid, output pid, output maxPower, input data);
endinterface
`default_nettype wire

// ==== logic/upi_desc_rom.sv ====
// descriptor image: one config, ep0 control, two interfaces, three endpoints
// assumes the caller registers the returned byte
`timescale 1ns/100ps
`default_nettype none
module upi_desc_rom (
  upi_desc_if.rom desc
);
  // fixed image; identity and power bytes are patched below
  localparam logic [7:0] IMAGE [0:upi_pkg::DESC_LEN-1] = '{
    8'h12, 8'h01, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h40,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02,
    8'h03, 8'h01,
    8'h09, 8'h02, 8'h30, 8'h00, 8'h02, 8'h01, 8'h00, 8'h80, 8'h00,
    8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01, 8'h00,
    8'h07, 8'h05, 8'h81, 8'h03, 8'h10, 8'h00, 8'h10,
    8'h09, 8'h04, 8'h01, 8'h00, 8'h02, 8'h0A, 8'h00, 8'h00, 8'h00,
    8'h07, 8'h05, 8'h82, 8'h02, 8'h40, 8'h00, 8'h00,
    8'h07, 8'h05, 8'h03, 8'h02, 8'h40, 8'h00, 8'h00};

  // identity override and power class patching
  always_comb begin
    case (int'(desc.addr))
      upi_pkg::VID_LO_IDX: desc.data = desc.vid[7:0];
      upi_pkg::VID_HI_IDX: desc.data = desc.vid[15:8];
      upi_pkg::PID_LO_IDX: desc.data = desc.pid[7:0];
      upi_pkg::PID_HI_IDX: desc.data = desc.pid[15:8];
      upi_pkg::MAXPWR_IDX: desc.data = desc.maxPower;
      default: begin
        // out of range reads return zero rather than wrap
        if (int'(desc.addr) < upi_pkg::DESC_LEN) begin
          desc.data = IMAGE[desc.addr];
        end else begin
          desc.data = 8'h00;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== logic/upi_pkg.sv ====
// constants for the usb power-state indicator block
// assumes one 200 MHz clock domain; otp values are steady levels
package upi_pkg;
  // power class boundary, one unit load in 2 mA units
  localparam logic [7:0] MAX_POWER_ONE_LOAD = 8'h32;
  // arbitrary neutral identity defaults
  localparam logic [15:0] DEFAULT_VID = 16'h0ABC;
  localparam logic [15:0] DEFAULT_PID = 16'h0DEF;
  localparam logic [7:0] DEFAULT_MAX_POWER = 8'h32;
  // configuration values
  localparam logic [7:0] CONFIG_ONE = 8'h01;
  localparam logic [7:0] CONFIG_NONE = 8'h00;
  // standard request codes
  localparam logic [7:0] REQ_GET_STATUS = 8'h00;
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
  localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
  // request type field layout
  localparam int RT_TYPE_MSB = 6;
  localparam int RT_TYPE_LSB = 5;
  localparam logic [1:0] RT_TYPE_STD = 2'h0;
  localparam logic [3:0] CONTROL_EP = 4'h0;
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_NONE = 7'h00;
  localparam logic [7:0] STATUS_BYTE = 8'h00;
  // descriptor image: device descriptor then configuration set
  localparam int DEV_DESC_LEN = 18;
  // config, two interfaces at 9 bytes each, three endpoints at 7 bytes each
  localparam int CFG_DESC_LEN = 48;
  localparam int DESC_LEN = DEV_DESC_LEN + CFG_DESC_LEN;
  // 66 bytes no longer fit a 6-bit index
  localparam int DESC_AW = 7;
  localparam int VID_LO_IDX = 8;
  localparam int VID_HI_IDX = 9;
  localparam int PID_LO_IDX = 10;
  localparam int PID_HI_IDX = 11;
  localparam int MAXPWR_IDX = DEV_DESC_LEN + 8;
  // reset levels
  localparam logic LOW_POWER_RESET = 1'b0;
  localparam logic PULLUP_RESET = 1'b0;
endpackage

// ==== logic/upi_power_state.sv ====
// usb attach, device state and low-power indication for a serial bridge
// assumes a link engine that decodes packets and hands over setup requests
`timescale 1ns/100ps
`default_nettype none
module upi_power_state (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic otpLowPowerInvert,
  input wire logic otpSenseGateEn,
  input wire logic otpVidValid,
  input wire logic [15:0] otpVid,
  input wire logic otpPidValid,
  input wire logic [15:0] otpPid,
  input wire logic otpMaxPowerValid,
  input wire logic [7:0] otpMaxPower,
  input wire logic busSupplyDetect,
  input wire logic usbBusReset,
  input wire logic usbSuspend,
  input wire logic setupValid,
  input wire logic [3:0] setupEndpoint,
  input wire logic [7:0] setupRequestType,
  input wire logic [7:0] setupRequest,
  input wire logic [15:0] setupValue,
  input wire logic statusDone,
  input wire logic descReadEn,
  input wire logic [upi_pkg::DESC_AW-1:0] descAddr,
  output logic lowPowerIndicator,
  output logic usbDataPlusPadPullupEn,
  output logic setupAck,
  output logic setupStall,
  output logic [7:0] replyByte,
  output logic [upi_pkg::ADDR_W-1:0] deviceAddress,
  output logic configured,
  output logic suspended,
  output logic [7:0] descData,
  output logic descValid
);
  typedef enum logic [1:0] {
    UPI_DEFAULT,
    UPI_ADDRESSED,
    UPI_CONFIGURED
  } upi_state_type;

  upi_state_type state_ff;
  upi_state_type nxt_state;
  logic [upi_pkg::ADDR_W-1:0] addr_ff;
  logic [upi_pkg::ADDR_W-1:0] nxt_addr;
  logic [upi_pkg::ADDR_W-1:0] pendAddr_ff;
  logic [upi_pkg::ADDR_W-1:0] nxt_pendAddr;
  logic pendValid_ff;
  logic nxt_pendValid;
  logic ack_ff;
  logic nxt_ack;
  logic stall_ff;
  logic nxt_stall;
  logic [7:0] reply_ff;
  logic [7:0] nxt_reply;
  logic configured_ff;
  logic nxt_configured;
  logic suspend_ff;
  logic nxt_suspend;
  logic low_power_indicator_ff;
  logic nxt_low_power_indicator;
  logic pullup_ff;
  logic nxt_pullup;
  logic [7:0] descData_ff;
  logic [7:0] nxt_descData;
  logic descValid_ff;
  logic nxt_descValid;
  logic [7:0] maxPower;
  logic isStd;
  logic lowPowerAsserted;

  upi_desc_if descBus ();

  // identity and power class with otp overrides
  assign maxPower = otpMaxPowerValid ? otpMaxPower : upi_pkg::DEFAULT_MAX_POWER;
  assign descBus.vid = otpVidValid ? otpVid : upi_pkg::DEFAULT_VID;
  assign descBus.pid = otpPidValid ? otpPid : upi_pkg::DEFAULT_PID;
  assign descBus.maxPower = maxPower;
  assign descBus.addr = descAddr;

  upi_desc_rom descRom (
    .desc(descBus)
  );

  assign isStd = setupRequestType[upi_pkg::RT_TYPE_MSB:upi_pkg::RT_TYPE_LSB] == upi_pkg::RT_TYPE_STD;

  // usb device state and standard request decode on ep0
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_pendAddr = pendAddr_ff;
    nxt_pendValid = pendValid_ff;
    nxt_ack = 1'b0;
    nxt_stall = 1'b0;
    nxt_reply = reply_ff;
    if (usbBusReset) begin
      // bus reset outranks any request in the same cycle
      nxt_state = UPI_DEFAULT;
      nxt_addr = upi_pkg::ADDR_NONE;
      nxt_pendValid = 1'b0;
    end else begin
      // new address applies only after the status stage, per usb
      if (statusDone && pendValid_ff) begin
        nxt_addr = pendAddr_ff;
        nxt_pendValid = 1'b0;
        if (pendAddr_ff == upi_pkg::ADDR_NONE) begin
          nxt_state = UPI_DEFAULT;
        end else if (state_ff == UPI_DEFAULT) begin
          nxt_state = UPI_ADDRESSED;
        end
      end
      if (setupValid) begin
        // non-zero endpoints and non-standard requests are refused
        if (setupEndpoint != upi_pkg::CONTROL_EP || !isStd) begin
          nxt_stall = 1'b1;
        end else begin
          case (setupRequest)
            upi_pkg::REQ_SET_ADDRESS: begin
              if (state_ff == UPI_CONFIGURED) begin
                nxt_stall = 1'b1;
              end else begin
                nxt_pendAddr = setupValue[upi_pkg::ADDR_W-1:0];
                nxt_pendValid = 1'b1;
                nxt_ack = 1'b1;
              end
            end
            upi_pkg::REQ_SET_CONFIG: begin
              if (state_ff == UPI_DEFAULT) begin
                nxt_stall = 1'b1;
              end else if (setupValue[7:0] == upi_pkg::CONFIG_ONE) begin
                nxt_state = UPI_CONFIGURED;
                nxt_ack = 1'b1;
              end else if (setupValue[7:0] == upi_pkg::CONFIG_NONE) begin
                nxt_state = UPI_ADDRESSED;
                nxt_ack = 1'b1;
              end else begin
                nxt_stall = 1'b1;
              end
            end
            upi_pkg::REQ_GET_CONFIG: begin
              nxt_reply = (state_ff == UPI_CONFIGURED) ? upi_pkg::CONFIG_ONE : upi_pkg::CONFIG_NONE;
              nxt_ack = 1'b1;
            end
            upi_pkg::REQ_GET_STATUS: begin
              nxt_reply = upi_pkg::STATUS_BYTE;
              nxt_ack = 1'b1;
            end
            upi_pkg::REQ_GET_DESCRIPTOR: begin
              // the bytes themselves come over the descriptor port
              nxt_ack = 1'b1;
            end
            default: begin
              nxt_stall = 1'b1;
            end
          endcase
        end
      end
    end
    // registered copy so the output comes straight from a flip-flop
    nxt_configured = (nxt_state == UPI_CONFIGURED);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= UPI_DEFAULT;
      configured_ff <= 1'b0;
      addr_ff <= upi_pkg::ADDR_NONE;
      pendAddr_ff <= upi_pkg::ADDR_NONE;
      pendValid_ff <= 1'b0;
      ack_ff <= 1'b0;
      stall_ff <= 1'b0;
      reply_ff <= upi_pkg::CONFIG_NONE;
    end else begin
      state_ff <= nxt_state;
      configured_ff <= nxt_configured;
      addr_ff <= nxt_addr;
      pendAddr_ff <= nxt_pendAddr;
      pendValid_ff <= nxt_pendValid;
      ack_ff <= nxt_ack;
      stall_ff <= nxt_stall;
      reply_ff <= nxt_reply;
    end
  end

  // power indication and attach gating
  always_comb begin
    nxt_suspend = usbSuspend && !usbBusReset;
    lowPowerAsserted = suspend_ff;
    if (maxPower > upi_pkg::MAX_POWER_ONE_LOAD && state_ff != UPI_CONFIGURED) begin
      lowPowerAsserted = 1'b1;
    end
    // default polarity drives low when asserted
    nxt_low_power_indicator = otpLowPowerInvert ? lowPowerAsserted : !lowPowerAsserted;
    // sense only matters when the otp enable picks it
    nxt_pullup = !(otpSenseGateEn && !busSupplyDetect);
  end

  // reset level is fixed low, the asserted level of the default polarity
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspend_ff <= 1'b0;
      low_power_indicator_ff <= upi_pkg::LOW_POWER_RESET;
      pullup_ff <= upi_pkg::PULLUP_RESET;
    end else begin
      suspend_ff <= nxt_suspend;
      low_power_indicator_ff <= nxt_low_power_indicator;
      pullup_ff <= nxt_pullup;
    end
  end

  // descriptor byte fetch, one cycle latency
  always_comb begin
    nxt_descValid = descReadEn;
    nxt_descData = descReadEn ? descBus.data : descData_ff;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      descData_ff <= 8'h00;
      descValid_ff <= 1'b0;
    end else begin
      descData_ff <= nxt_descData;
      descValid_ff <= nxt_descValid;
    end
  end

  // all outputs come straight from flip-flops
  assign lowPowerIndicator = low_power_indicator_ff;
  assign usbDataPlusPadPullupEn = pullup_ff;
  assign setupAck = ack_ff;
  assign setupStall = stall_ff;
  assign replyByte = reply_ff;
  assign deviceAddress = addr_ff;
  assign configured = configured_ff;
  assign suspended = suspend_ff;
  assign descData = descData_ff;
  assign descValid = descValid_ff;
endmodule
`default_nettype wire

// ==== sim/upi_power_state_monitor.sv ====
// checker for the power-state block, watching top-level ports only
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module upi_power_state_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic otpLowPowerInvert,
  input wire logic otpSenseGateEn,
  input wire logic otpMaxPowerValid,
  input wire logic [7:0] otpMaxPower,
  input wire logic busSupplyDetect,
  input wire logic usbBusReset,
  input wire logic usbSuspend,
  input wire logic setupValid,
  input wire logic [3:0] setupEndpoint,
  input wire logic [15:0] setupValue,
  input wire logic descReadEn,
  input wire logic lowPowerIndicator,
  input wire logic usbDataPlusPadPullupEn,
  input wire logic setupAck,
  input wire logic setupStall,
  input wire logic configured,
  input wire logic suspended,
  input wire logic descValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // full current forbidden by suspend, or by a high class while unconfigured
  logic [7:0] mpEff;
  logic assertNow;
  assign mpEff = otpMaxPowerValid ? otpMaxPower : upi_pkg::DEFAULT_MAX_POWER;
  assign assertNow = suspended | ((mpEff > upi_pkg::MAX_POWER_ONE_LOAD) & ~configured);
  a_indicator_level: assert property (1 |=> lowPowerIndicator == ($past(assertNow) ~^ $past(otpLowPowerInvert)))
    else $error("indicator level wrong");
  a_suspend_follow: assert property (!usbBusReset |=> suspended == $past(usbSuspend))
    else $error("suspend state lags");
  a_suspend_indicator: assert property ($rose(usbSuspend) && !usbBusReset |-> ##2 lowPowerIndicator == otpLowPowerInvert)
    else $error("suspend not shown");
  a_pullup_gate: assert property (1 |=> usbDataPlusPadPullupEn == !($past(otpSenseGateEn) && !$past(busSupplyDetect)))
    else $error("pull-up gating wrong");
  a_answer_one: assert property (setupValid && !usbBusReset |=> setupAck != setupStall)
    else $error("setup answer missing");
  a_endpoint_stall: assert property (setupValid && !usbBusReset && setupEndpoint != upi_pkg::CONTROL_EP |=> setupStall)
    else $error("foreign endpoint accepted");
  a_config_cause: assert property ($rose(configured) |-> $past(setupValid) && $past(setupValue) == 16'h0001)
    else $error("configured without value one");
  a_bus_reset: assert property (usbBusReset |=> !configured && !setupAck && !setupStall)
    else $error("bus reset kept state");
  a_desc_answer: assert property (descReadEn |=> descValid)
    else $error("descriptor byte missing");
  c_config: cover property ($rose(configured));
  c_suspend: cover property ($rose(suspended));
  c_stall: cover property (setupStall);
endmodule
bind upi_power_state upi_power_state_monitor upi_power_state_monitor_i (.sys_clk(sys_clk), .rst(rst),
  .otpLowPowerInvert(otpLowPowerInvert), .otpSenseGateEn(otpSenseGateEn), .otpMaxPowerValid(otpMaxPowerValid),
  .otpMaxPower(otpMaxPower), .busSupplyDetect(busSupplyDetect), .usbBusReset(usbBusReset), .usbSuspend(usbSuspend),
  .setupValid(setupValid), .setupEndpoint(setupEndpoint), .setupValue(setupValue), .descReadEn(descReadEn),
  .lowPowerIndicator(lowPowerIndicator), .usbDataPlusPadPullupEn(usbDataPlusPadPullupEn), .setupAck(setupAck),
  .setupStall(setupStall), .configured(configured), .suspended(suspended), .descValid(descValid));
`default_nettype wire

// ==== sim/upi_power_state_tb.sv ====
// self-checking bench for the usb power-state block
// assumes the bench plays the link engine and a model plays the board switch
`timescale 1ns/100ps
`default_nettype none
module upi_power_state_tb;
  logic sys_clk = 1'b0, rst = 1'b1, otpLowPowerInvert = 1'b0, otpSenseGateEn = 1'b0, otpVidValid = 1'b0;
  logic otpPidValid = 1'b0, otpMaxPowerValid = 1'b0, busSupplyDetect = 1'b1, usbBusReset = 1'b0;
  logic usbSuspend = 1'b0, setupValid = 1'b0, statusDone = 1'b0, descReadEn = 1'b0, cfg = 1'b0;
  logic [15:0] otpVid = 16'h0000, otpPid = 16'h0000, setupValue = 16'h0000, vidE, pidE;
  logic [7:0] otpMaxPower = 8'h00, setupRequestType = 8'h00, setupRequest = 8'h00, replyByte, descData;
  logic [3:0] setupEndpoint = 4'h0;
  logic [6:0] descAddr = 7'h00;
  logic [6:0] deviceAddress;
  logic lowPowerIndicator, usbDataPlusPadPullupEn, setupAck, setupStall, configured, suspended, descValid, highCurrentOk;
  logic [31:0] r;
  integer seed = 96, failures = 0, checked = 0;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  upi_power_state upi_power_state_i (.sys_clk(sys_clk), .rst(rst), .otpLowPowerInvert(otpLowPowerInvert),
    .otpSenseGateEn(otpSenseGateEn), .otpVidValid(otpVidValid), .otpVid(otpVid), .otpPidValid(otpPidValid),
    .otpPid(otpPid), .otpMaxPowerValid(otpMaxPowerValid), .otpMaxPower(otpMaxPower),
    .busSupplyDetect(busSupplyDetect), .usbBusReset(usbBusReset), .usbSuspend(usbSuspend),
    .setupValid(setupValid), .setupEndpoint(setupEndpoint), .setupRequestType(setupRequestType),
    .setupRequest(setupRequest), .setupValue(setupValue), .statusDone(statusDone), .descReadEn(descReadEn),
    .descAddr(descAddr), .lowPowerIndicator(lowPowerIndicator), .usbDataPlusPadPullupEn(usbDataPlusPadPullupEn),
    .setupAck(setupAck), .setupStall(setupStall), .replyByte(replyByte), .deviceAddress(deviceAddress),
    .configured(configured), .suspended(suspended), .descData(descData), .descValid(descValid));
  upi_power_switch_model upi_power_switch_model_i (.lowPowerIndicator(lowPowerIndicator),
    .polarityInvert(otpLowPowerInvert), .highCurrentOk(highCurrentOk));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits land 1 ns past the edge so registered outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one setup request; answer comes exactly one cycle later
  task automatic setup(input logic [3:0] ep, input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
                       input logic ok);
    @(posedge sys_clk);
    setupEndpoint <= ep;
    setupRequestType <= rt;
    setupRequest <= rq;
    setupValue <= v;
    setupValid <= 1'b1;
    @(posedge sys_clk);
    setupValid <= 1'b0;
    #1;
    chk({setupAck, setupStall}, ok ? 2'h2 : 2'h1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    descAddr <= a;
    descReadEn <= 1'b1;
    @(posedge sys_clk);
    descReadEn <= 1'b0;
    #1;
    chk({descValid, descData}, {1'b1, e});
  endtask
  function automatic logic expInd(input logic s, input logic c, input logic [7:0] mp, input logic inv);
    return inv ~^ (s | (mp > upi_pkg::MAX_POWER_ONE_LOAD && !c));
  endfunction
  task automatic conclude;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, counted as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    conclude;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    w(3);
    chk(lowPowerIndicator, 1'b1);
    @(posedge sys_clk);
    otpMaxPowerValid <= 1'b1;
    otpMaxPower <= 8'h33;
    w(3);
    chk(lowPowerIndicator, 1'b0);
    chk(highCurrentOk, 1'b0);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_CONFIG, 16'h0001, 1'b0);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_ADDRESS, 16'h0005, 1'b1);
    @(posedge sys_clk);
    statusDone <= 1'b1;
    @(posedge sys_clk);
    statusDone <= 1'b0;
    w(1);
    chk(deviceAddress, 7'h05);
    setup(4'h1, 8'h00, upi_pkg::REQ_GET_STATUS, 16'h0000, 1'b0);
    setup(4'h0, 8'h40, upi_pkg::REQ_GET_STATUS, 16'h0000, 1'b0);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_CONFIG, 16'h0002, 1'b0);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_CONFIG, 16'h0001, 1'b1);
    w(1);
    chk({configured, lowPowerIndicator}, 2'h3);
    setup(4'h0, 8'h80, upi_pkg::REQ_GET_CONFIG, 16'h0000, 1'b1);
    chk(replyByte, upi_pkg::CONFIG_ONE);
    setup(4'h0, 8'h80, upi_pkg::REQ_GET_DESCRIPTOR, 16'h0100, 1'b1);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_CONFIG, 16'h0000, 1'b1);
    w(1);
    chk({configured, lowPowerIndicator}, 2'h0);
    setup(4'h0, 8'h80, upi_pkg::REQ_GET_CONFIG, 16'h0000, 1'b1);
    chk(replyByte, upi_pkg::CONFIG_NONE);
    setup(4'h0, 8'h00, 8'h03, 16'h0000, 1'b0);
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_CONFIG, 16'h0001, 1'b1);
    cfg = 1'b1;
    // address change is refused once configured
    setup(4'h0, 8'h00, upi_pkg::REQ_SET_ADDRESS, 16'h0007, 1'b0);
    // random power states; halfway a bus reset drops the configuration
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        @(posedge sys_clk);
        usbSuspend <= 1'b0;
        usbBusReset <= 1'b1;
        @(posedge sys_clk);
        usbBusReset <= 1'b0;
        w(1);
        chk(configured, 1'b0);
        cfg = 1'b0;
      end
      r = $random(seed);
      @(posedge sys_clk);
      usbSuspend <= r[0];
      otpLowPowerInvert <= r[1];
      otpSenseGateEn <= r[2];
      busSupplyDetect <= r[3];
      otpMaxPower <= r[11:4];
      w(3);
      chk(lowPowerIndicator, expInd(usbSuspend, cfg, otpMaxPower, otpLowPowerInvert));
      chk(usbDataPlusPadPullupEn, !(otpSenseGateEn && !busSupplyDetect));
      chk(suspended, usbSuspend);
      chk(highCurrentOk, !usbSuspend && (cfg || otpMaxPower <= upi_pkg::MAX_POWER_ONE_LOAD));
    end
    // identity bytes: defaults first, then otp overrides
    vidE = upi_pkg::DEFAULT_VID;
    pidE = upi_pkg::DEFAULT_PID;
    for (int k = 0; k < 2; k++) begin
      rd(7'h08, vidE[7:0]);
      rd(7'h09, vidE[15:8]);
      rd(7'h0A, pidE[7:0]);
      rd(7'h0B, pidE[15:8]);
      r = $random(seed);
      vidE = r[15:0];
      pidE = r[31:16];
      @(posedge sys_clk);
      otpVid <= vidE;
      otpPid <= pidE;
      otpVidValid <= 1'b1;
      otpPidValid <= 1'b1;
    end
    // first index past the 66-byte image reads zero
    rd(7'h42, 8'h00);
    // declared power byte follows the otp value
    rd(7'h1A, otpMaxPower);
    conclude;
  end
endmodule
`default_nettype wire

// ==== sim/upi_power_switch_model.sv ====
// board power switch model reading the low-power indicator
// assumes it is told the programmed polarity of the indicator
`timescale 1ns/100ps
`default_nettype none
module upi_power_switch_model (
  input wire logic lowPowerIndicator,
  input wire logic polarityInvert,
  output logic highCurrentOk
);
  // full current only while the indicator sits at its deasserted level
  assign highCurrentOk = lowPowerIndicator ^ polarityInvert;
endmodule
`default_nettype wire
